// ===== hdl/igas_pkg.sv
// Register map, field layout and carriers for the auto-start block.
package igas_pkg;
	localparam int IGAS_PRESS_W = 16;
	localparam logic [7:0] IGAS_ADDR_CTRL = 8'h00;
	localparam logic [7:0] IGAS_ADDR_THRESH = 8'h04;
	localparam logic [7:0] IGAS_ADDR_STATUS = 8'h08;
	localparam logic [7:0] IGAS_ADDR_CMD = 8'h0C;
	localparam int IGAS_CTRL_PG_SEL = 0;
	localparam int IGAS_CTRL_IG_SEL = 1;
	localparam int IGAS_CMD_ARM = 0;
	localparam int IGAS_CMD_DISARM = 1;
	localparam int IGAS_ST_ARMED = 0;
	localparam int IGAS_ST_IG1 = 1;
	localparam int IGAS_ST_IG2 = 2;
	localparam logic [1:0] IGAS_CTRL_RST = 2'h0;
	localparam logic [15:0] IGAS_THRESH_RST = 16'h0100;

	typedef struct packed {
		logic valid;
		logic [IGAS_PRESS_W-1:0] value;
	} igas_sample_t;

	typedef struct packed {
		logic first_ion_gauge_on;
		logic second_ion_gauge_on;
	} igas_gauges_t;
endpackage

// ===== hdl/igas_cmp.sv
// Threshold and 1.2x hysteresis comparator for one pressure sample.
`timescale 1ns/10ps
module igas_cmp
	import igas_pkg::*;
#(
	parameter int W = IGAS_PRESS_W
) (
	input wire logic [W-1:0] i_press,
	input wire logic [W-1:0] i_thresh,
	output logic o_below,
	output logic o_above_trip
);
	if (W < 1) begin : g_bad_width
		$error("W must be at least one");
	end

	// Trip level 1.2*T computed as (6*T)/5 with headroom bits.
	wire [W+2:0] six_t = ({3'h0, i_thresh} << 2) + ({3'h0, i_thresh} << 1);
	wire [W+2:0] trip = six_t / (W+3)'(5);
	assign o_below = i_press < i_thresh;
	assign o_above_trip = {3'h0, i_press} > trip;
endmodule

// ===== hdl/igas_ctrl.sv
// Ion gauge auto-start controller with a classic Wishbone register slave.
// Operation
// - Armed: turn chosen ion gauge on when reading falls below threshold.
// - Armed, gauge on: turn it off when reading exceeds 1.2 times threshold.
// - After switching on, auto-start stays armed and keeps monitoring.
// - A setting picks which thermal gauge feeds the comparisons.
// - A setting picks which ion gauge port auto-start controls.
// - Only one ion gauge runs; auto-start on one forces the other off.
// - An auto-start button press with no manual press or host arm/disarm in its cycle toggles armed and disarmed.
// - A press of either manual ion gauge button disarms auto-start.
// - Remote host may arm auto-start, same effect as local arming.
`timescale 1ns/10ps
module igas_ctrl
	import igas_pkg::*;
#(
	parameter int PRESS_W = IGAS_PRESS_W
) (
	input wire logic I_REF_CLK,
	input wire logic I_RESET_N,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [31:0] I_WB_DAT,
	input wire logic [3:0] I_WB_SEL,
	input wire logic I_WB_WE,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	input wire igas_sample_t I_FIRST_THERMAL_GAUGE,
	input wire igas_sample_t I_SECOND_THERMAL_GAUGE,
	input wire logic I_AUTOSTART_BUTTON,
	input wire logic I_FIRST_ION_GAUGE_BUTTON,
	input wire logic I_SECOND_ION_GAUGE_BUTTON,
	output igas_gauges_t O_ION_GAUGES,
	output logic O_ION_GAUGE_AUTOSTART
);
	// Registers and carriers are fixed at the package pressure width.
	if (PRESS_W != IGAS_PRESS_W) begin : g_bad_width
		$error("PRESS_W must equal package pressure width");
	end

	// Button pins are asynchronous: two flops, then an edge detector.
	logic [2:0] btn_s1;
	logic [2:0] btn_s2;
	logic [2:0] btn_d;
	logic [1:0] ctrl;
	logic [15:0] thresh;
	logic armed;
	logic ig1_on;
	logic ig2_on;
	logic ack;
	logic [31:0] rdat;

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			btn_s1 <= 3'h0;
			btn_s2 <= 3'h0;
			btn_d <= 3'h0;
		end else begin
			btn_s1 <= {I_SECOND_ION_GAUGE_BUTTON, I_FIRST_ION_GAUGE_BUTTON,
				I_AUTOSTART_BUTTON};
			btn_s2 <= btn_s1;
			btn_d <= btn_s2;
		end
	end
	wire [2:0] btn_press = btn_s2 & ~btn_d;
	wire auto_press = btn_press[0];
	wire manual_press = btn_press[1] | btn_press[2];

	// Wishbone decode.
	wire wb_req = I_WB_CYC & I_WB_STB & ~ack;
	wire wb_wr = wb_req & I_WB_WE;
	wire hit_ctrl = I_WB_ADR == IGAS_ADDR_CTRL;
	wire hit_thr = I_WB_ADR == IGAS_ADDR_THRESH;
	wire hit_st = I_WB_ADR == IGAS_ADDR_STATUS;
	wire hit_cmd = I_WB_ADR == IGAS_ADDR_CMD;
	wire wr_ctrl = wb_wr & hit_ctrl & I_WB_SEL[0];
	wire wr_cmd = wb_wr & hit_cmd & I_WB_SEL[0];
	wire host_arm = wr_cmd & I_WB_DAT[IGAS_CMD_ARM];
	wire host_disarm = wr_cmd & I_WB_DAT[IGAS_CMD_DISARM];
	wire [31:0] next_rdat = hit_ctrl ? {30'h0, ctrl} :
		hit_thr ? {16'h0, thresh} :
		hit_st ? {29'h0, ig2_on, ig1_on, armed} : 32'h0;

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			ack <= 1'b0;
			rdat <= 32'h0;
		end else begin
			ack <= wb_req;
			if (wb_req) begin
				rdat <= next_rdat;
			end
		end
	end
	assign O_WB_ACK = ack;
	assign O_WB_DAT = rdat;

	// Configuration storage; read live by the comparison path.
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			ctrl <= IGAS_CTRL_RST;
			thresh <= IGAS_THRESH_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl <= I_WB_DAT[1:0];
			end
			if (wb_wr & hit_thr) begin
				if (I_WB_SEL[0]) begin
					thresh[7:0] <= I_WB_DAT[7:0];
				end
				if (I_WB_SEL[1]) begin
					thresh[15:8] <= I_WB_DAT[15:8];
				end
			end
		end
	end

	// Monitored sample selection.
	wire pg_sel = ctrl[IGAS_CTRL_PG_SEL];
	wire ig_sel = ctrl[IGAS_CTRL_IG_SEL];
	wire igas_sample_t mon = pg_sel ? I_SECOND_THERMAL_GAUGE :
		I_FIRST_THERMAL_GAUGE;
	logic below;
	logic above_trip;

	igas_cmp #(
		.W(PRESS_W)
	) u_cmp (
		.i_press(mon.value),
		.i_thresh(thresh),
		.o_below(below),
		.o_above_trip(above_trip)
	);

	// Arming: disarm by manual buttons wins, then host, then toggle.
	wire next_armed = manual_press ? 1'b0 :
		host_disarm ? 1'b0 :
		host_arm ? 1'b1 :
		auto_press ? ~armed : armed;
	wire sel_on = ig_sel ? ig2_on : ig1_on;
	wire turn_on = armed & mon.valid & below & ~sel_on;
	wire turn_off = armed & mon.valid & above_trip & sel_on;
	wire next_sel_on = turn_off ? 1'b0 : (turn_on ? 1'b1 : sel_on);
	// Manual buttons toggle their own gauge while auto-start is dropped; if both are pressed, the first toggles and the second goes off.
	wire next_ig1 = manual_press ? (btn_press[1] ? ~ig1_on : 1'b0) :
		armed ? (ig_sel ? 1'b0 : next_sel_on) : ig1_on;
	wire next_ig2 = manual_press ? (btn_press[2] & ~btn_press[1] ?
		~ig2_on : 1'b0) :
		armed ? (ig_sel ? next_sel_on : 1'b0) : ig2_on;

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			armed <= 1'b0;
			ig1_on <= 1'b0;
			ig2_on <= 1'b0;
		end else begin
			armed <= next_armed;
			ig1_on <= next_ig1;
			ig2_on <= next_ig2;
		end
	end
	assign O_ION_GAUGES = '{first_ion_gauge_on: ig1_on,
		second_ion_gauge_on: ig2_on};
	assign O_ION_GAUGE_AUTOSTART = armed;

	property p_on;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		turn_on & ~manual_press |=> ($past(ig_sel) ? ig2_on : ig1_on);
	endproperty
	a_on: assert property (p_on) else $error("gauge not switched on");

	property p_off;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		turn_off & ~manual_press |=> !(ig1_on | ig2_on) &&
			(armed || $past(host_disarm | auto_press));
	endproperty
	a_off: assert property (p_off) else $error("gauge not tripped");

	property p_stay;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		armed & ~manual_press & ~host_disarm & ~auto_press |=> armed;
	endproperty
	a_stay: assert property (p_stay) else $error("auto dropped");

	property p_one;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		!(ig1_on && ig2_on);
	endproperty
	a_one: assert property (p_one) else $error("two gauges on");

	property p_other;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		armed & ~manual_press |=> ($past(ig_sel) ? !ig1_on : !ig2_on);
	endproperty
	a_other: assert property (p_other) else $error("other not off");

	property p_tog;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		auto_press & ~manual_press & ~wr_cmd |=> armed != $past(armed);
	endproperty
	a_tog: assert property (p_tog) else $error("no toggle");

	property p_man;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		manual_press |=> !armed;
	endproperty
	a_man: assert property (p_man) else $error("manual no disarm");

	property p_host;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		host_arm & ~host_disarm & ~manual_press |=> armed && O_WB_ACK;
	endproperty
	a_host: assert property (p_host) else $error("host arm lost");

	property p_nosample;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		armed & ~mon.valid & ~manual_press & $past(armed) &
			(ig_sel == $past(ig_sel)) |=> $stable(O_ION_GAUGES);
	endproperty
	a_nosample: assert property (p_nosample)
		else $error("moved w/o sample");

	property p_ack_pulse;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		O_WB_ACK |=> !O_WB_ACK;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held");

	property p_ack_req;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		wb_req |=> O_WB_ACK;
	endproperty
	a_ack_req: assert property (p_ack_req)
		else $error("no ack");

	property p_ack_idle;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		!(I_WB_CYC & I_WB_STB) |=> !O_WB_ACK;
	endproperty
	a_ack_idle: assert property (p_ack_idle)
		else $error("ack without request");

	property p_rd_status;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		wb_req & ~I_WB_WE & hit_st |=>
			O_WB_DAT[IGAS_ST_ARMED] == $past(armed) &&
			O_WB_DAT[IGAS_ST_IG1] == $past(ig1_on) &&
			O_WB_DAT[IGAS_ST_IG2] == $past(ig2_on);
	endproperty
	a_rd_status: assert property (p_rd_status)
		else $error("status read wrong");

	property p_rd_zero;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		wb_req & ~I_WB_WE & ~hit_ctrl & ~hit_thr & ~hit_st |=>
			O_WB_DAT == 32'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("command or hole read not zero");

	property p_ctrl_wr;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		wr_ctrl |=> ctrl == $past(I_WB_DAT[1:0]);
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr)
		else $error("control not stored");

	property p_thr_lo;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		wb_wr & hit_thr & I_WB_SEL[0] |=>
			thresh[7:0] == $past(I_WB_DAT[7:0]);
	endproperty
	a_thr_lo: assert property (p_thr_lo)
		else $error("threshold low byte not stored");

	property p_thr_hi;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		wb_wr & hit_thr & I_WB_SEL[1] |=>
			thresh[15:8] == $past(I_WB_DAT[15:8]);
	endproperty
	a_thr_hi: assert property (p_thr_hi)
		else $error("threshold high byte not stored");

	property p_host_dis;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		host_disarm & ~manual_press |=> !armed;
	endproperty
	a_host_dis: assert property (p_host_dis)
		else $error("host disarm lost");

	property p_hold;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		armed & mon.valid & sel_on & ~above_trip & ~manual_press |=>
			($past(ig_sel) ? ig2_on : ig1_on);
	endproperty
	a_hold: assert property (p_hold)
		else $error("gauge dropped inside hysteresis");

	property p_wait;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		armed & mon.valid & ~below & ~sel_on & ~manual_press |=>
			!($past(ig_sel) ? ig2_on : ig1_on);
	endproperty
	a_wait: assert property (p_wait)
		else $error("gauge started above threshold");

	property p_disarmed;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		!armed & ~manual_press |=> $stable(O_ION_GAUGES);
	endproperty
	a_disarmed: assert property (p_disarmed)
		else $error("gauges moved while disarmed");

	property p_man_other;
		@(posedge I_REF_CLK) disable iff (!I_RESET_N)
		manual_press |=> ($past(btn_press[1]) ? !ig2_on : !ig1_on);
	endproperty
	a_man_other: assert property (p_man_other)
		else $error("other gauge left on");
endmodule

// ===== test/igas_front_end.sv
// Model of the front end that delivers one sample per gauge on request.
`timescale 1ns/10ps
module igas_front_end import igas_pkg::*; (
	input wire logic i_clk,
	input wire logic i_fire,
	input wire logic [15:0] i_first,
	input wire logic [15:0] i_second,
	output igas_sample_t o_first,
	output igas_sample_t o_second
);
	// Between samples the value lines flip to expose any stale read.
	always_ff @(posedge i_clk) begin
		o_first <= '{i_fire, i_fire ? i_first : ~o_first.value};
		o_second <= '{i_fire, i_fire ? i_second : ~o_second.value};
	end
endmodule

// ===== test/igas_ctrl_test.sv
// Self-checking bench for the ion gauge auto-start controller.
`timescale 1ns/10ps
module igas_ctrl_test import igas_pkg::*;;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, fire = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rd, rdat;
	logic [15:0] p1 = 16'h0, p2 = 16'h0;
	logic [2:0] btn = 3'h0;
	logic ack, armed;
	igas_gauges_t ion;
	igas_sample_t s1, s2;
	int errors = 0, tests_run = 0;
	localparam logic [17:0] ROWS [5] = '{{16'h03E8, 2'h0}, {16'h03E7, 2'h2},
		{16'h04B0, 2'h2}, {16'h04B1, 2'h0}, {16'h03E7, 2'h2}};
	localparam logic [39:0] RSTV [5] = '{{IGAS_ADDR_CTRL, 30'h0, IGAS_CTRL_RST},
		{IGAS_ADDR_THRESH, 16'h0, IGAS_THRESH_RST}, {IGAS_ADDR_STATUS, 32'h0},
		{IGAS_ADDR_CMD, 32'h0}, {8'h10, 32'h0}};
	igas_front_end fe (.i_clk(clk), .i_fire(fire), .i_first(p1),
		.i_second(p2), .o_first(s1), .o_second(s2));
	igas_ctrl dut (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_WB_ADR(adr),
		.I_WB_DAT(wdat), .I_WB_SEL(4'hF), .I_WB_WE(we), .I_WB_CYC(cyc),
		.I_WB_STB(stb), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.I_FIRST_THERMAL_GAUGE(s1), .I_SECOND_THERMAL_GAUGE(s2),
		.I_AUTOSTART_BUTTON(btn[0]), .I_FIRST_ION_GAUGE_BUTTON(btn[1]),
		.I_SECOND_ION_GAUGE_BUTTON(btn[2]), .O_ION_GAUGES(ion),
		.O_ION_GAUGE_AUTOSTART(armed));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		we <= w;
		wdat <= d;
		cyc <= 1'h1;
		stb <= 1'h1;
		// Ack and read data are taken at the rising edge that sees ack high.
		do @(posedge clk); while (ack !== 1'h1 && ++n < 50);
		if (n >= 50) errors++;
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
	task automatic smp(input logic [15:0] a, input logic [15:0] b);
		fire <= 1'b1;
		p1 <= a;
		p2 <= b;
		@(posedge clk);
		fire <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic press(input int i);
		btn[i] <= 1'b1;
		repeat (6) @(posedge clk);
		btn[i] <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task automatic complete_run;
		$display("tests_run=%0d errors=%0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		complete_run();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (RSTV[i]) begin
			wb(RSTV[i][39:32], 1'b0, 32'h0);
			chk(rd, RSTV[i][31:0]);
		end
		wb(8'h04, 1'b1, 32'h3E8);
		wb(8'h0C, 1'b1, 32'h1);
		chk(32'(armed), 32'h1);
		foreach (ROWS[i]) begin
			smp(ROWS[i][17:2], 16'h0);
			chk(32'(ion), 32'(ROWS[i][1:0]));
			chk(32'(armed), 32'h1);
		end
		wb(8'h00, 1'b1, 32'h1);
		smp(16'h0, 16'h04B1);
		chk(32'(ion), 32'h0);
		smp(16'h0, 16'h0);
		chk(32'(ion), 32'h2);
		wb(8'h00, 1'b1, 32'h3);
		smp(16'h0, 16'h0);
		chk(32'(ion), 32'h1);
		wb(8'h08, 1'b0, 32'h0);
		chk(rd, 32'h5);
		press(0);
		chk(32'(armed), 32'h0);
		press(0);
		chk(32'(armed), 32'h1);
		press(2);
		chk(32'(armed), 32'h0);
		press(0);
		press(1);
		chk(32'(armed), 32'h0);
		wb(IGAS_ADDR_CMD, 1'h1, 32'h1);
		chk(32'(armed), 32'h1);
		chk(32'(ion), 32'h0);
		wb(IGAS_ADDR_CMD, 1'h1, 32'h2);
		chk(32'(armed), 32'h0);
		rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(32'({ion, armed}), 32'h0);
		wb(IGAS_ADDR_THRESH, 1'h0, 32'h0);
		chk(rd, {16'h0, IGAS_THRESH_RST});
		complete_run();
	end
endmodule
